// [logic/vfp_pkg.sv]
// Purpose: shared constants, types and helpers for the v/f curve and phase loss block
// Assumes: frequencies in 0.1 Hz steps, voltages in 0.1 V steps, 50 MHz clock
// Notes:   every offset, reset value and timing count lives here once
package vfp_pkg;

    // clock and timing
    localparam int CLK_HZ         = 50_000_000;
    localparam int INTERVAL_MS    = 1280;
    localparam int FAULT_DELAY_MS = 10240;
    localparam int INTERVAL_CYC   = INTERVAL_MS * (CLK_HZ / 1000);
    localparam int FAULT_CYC      = FAULT_DELAY_MS * (CLK_HZ / 1000);

    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_MAXF   = 8'h04;
    localparam logic [7:0] OFS_MAXV   = 8'h08;
    localparam logic [7:0] OFS_KNEEF  = 8'h0c;
    localparam logic [7:0] OFS_MIDF   = 8'h10;
    localparam logic [7:0] OFS_MIDV   = 8'h14;
    localparam logic [7:0] OFS_MINF   = 8'h18;
    localparam logic [7:0] OFS_MINV   = 8'h1c;
    localparam logic [7:0] OFS_RATED  = 8'h20;
    localparam logic [7:0] OFS_LEVEL  = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;
    localparam logic [7:0] OFS_MASK   = 8'h2c;
    localparam logic [7:0] OFS_STATE  = 8'h30;

    // status bit positions
    localparam int ST_CURVE  = 0;
    localparam int ST_DETECT = 1;
    localparam int ST_FAULT  = 2;
    localparam int ST_REFUSE = 3;
    localparam int NST       = 4;

    // reset values
    localparam logic        RST_PATTERN = 1'b1;
    localparam logic [15:0] RST_RATED   = 16'h08fc;
    localparam logic [7:0]  RST_LEVEL   = 8'h07;

    // limits
    localparam logic [7:0]  LEVEL_MIN   = 8'h01;
    localparam logic [7:0]  LEVEL_MAX   = 8'h64;
    localparam logic [7:0]  CURRENT_MIN = 8'h1e;
    localparam logic [15:0] RATED_MIN   = 16'h05dc;
    localparam logic [15:0] RATED_230   = 16'h09f6;
    localparam logic [15:0] RATED_460   = 16'h13ec;
    localparam logic [15:0] RATED_575   = 16'h1ca3;
    localparam logic [15:0] BASE_VOLT   = 16'h08fc;

    typedef enum logic [1:0] {CLS_230, CLS_460, CLS_575} vfp_class_e;

    typedef struct packed {
        logic [15:0] maxF;
        logic [15:0] maxV;
        logic [15:0] kneeF;
        logic [15:0] midF;
        logic [15:0] midV;
        logic [15:0] minF;
        logic [15:0] minV;
    } vfp_curve_s;

    // factory custom curve and fixed preset curve
    localparam vfp_curve_s CUSTOM_RST = '{16'h0258, 16'h08fc, 16'h0258,
                                          16'h012c, 16'h023f, 16'h000f, 16'h0073};
    localparam vfp_curve_s PRESET     = '{16'h0258, 16'h08fc, 16'h0258,
                                          16'h001e, 16'h00ac, 16'h000f, 16'h0073};

    // ordering check of a curve
    function automatic logic vfp_curve_ok(input vfp_curve_s c);
        vfp_curve_ok = (c.maxF >= c.kneeF) && (c.kneeF >= c.midF) && (c.midF >= c.minF)
                    && (c.maxV >= c.midV) && (c.midV >= c.minV);
    endfunction

endpackage

// [logic/vfp_interp.sv]
// Purpose: turns an output frequency into a curve voltage
// Assumes: curve already passed the ordering check
// Notes:   result registered one cycle after the frequency
`timescale 1ns/1ps
module vfp_interp (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               nrst,
    // curve and frequency
    input  wire vfp_pkg::vfp_curve_s curve,
    input  wire logic [15:0]        freq,
    // result
    output logic [15:0]             volt_q
);
    import vfp_pkg::*;

    logic [15:0] volt_d;

    // straight line between two points, flat when the span is empty
    function automatic logic [15:0] lerp(input logic [15:0] f, input logic [15:0] f0,
                                         input logic [15:0] f1, input logic [15:0] v0,
                                         input logic [15:0] v1);
        logic [31:0] num;
        logic [15:0] dv;
        logic [15:0] df;
        dv  = v1 - v0;
        df  = f1 - f0;
        num = 32'(dv) * 32'(16'(f - f0));
        if (df == 16'h0000) begin
            lerp = v1;
        end else begin
            lerp = v0 + 16'(num / 32'(df));
        end
    endfunction

    // piecewise curve; above the knee the voltage stays at maximum
    always_comb begin
        if (freq >= curve.kneeF) begin
            volt_d = curve.maxV;
        end else if (freq <= curve.minF) begin
            volt_d = curve.minV;
        end else if (curve.midF == curve.minF) begin
            volt_d = lerp(freq, curve.minF, curve.kneeF, curve.minV, curve.maxV); // [R7]
        end else if (freq < curve.midF) begin
            volt_d = lerp(freq, curve.minF, curve.midF, curve.minV, curve.midV);
        end else begin
            volt_d = lerp(freq, curve.midF, curve.kneeF, curve.midV, curve.maxV);
        end
    end

    // output register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            volt_q <= 16'h0000;
        end else begin
            volt_q <= volt_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_knee_flat: assert property ( // [R3]
        freq >= curve.kneeF |=> volt_q == $past(curve.maxV))
        else $error("voltage above knee is not maximum");
    a_straight_line: assert property ( // [R7]
        (curve.midF == curve.minF && curve.minV <= curve.maxV)
        |=> (volt_q >= $past(curve.minV) && volt_q <= $past(curve.maxV)))
        else $error("straight line leaves min to max band");

endmodule

// [logic/vfp_ripple.sv]
// Purpose: bus voltage spread over fixed intervals
// Assumes: bus sample is synchronous to clk
// Notes:   delta and done pulse arrive together at each interval end
`timescale 1ns/1ps
module vfp_ripple #(
    parameter int BW       = 12,
    parameter int INTERVAL = vfp_pkg::INTERVAL_CYC
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          nrst,
    // bus sample
    input  wire logic [BW-1:0] busV,
    // interval result
    output logic [BW-1:0]      delta_q,
    output logic               done_q
);
    import vfp_pkg::*;

    logic [31:0]   cnt_q;
    logic [BW-1:0] hi_q;
    logic [BW-1:0] lo_q;
    logic          last;

    assign last = (cnt_q == 32'(INTERVAL - 1));

    // interval counter
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_q <= 32'h0000_0000;
        end else if (last) begin
            cnt_q <= 32'h0000_0000;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end

    // running extremes, restarted from the current sample each interval
    always_ff @(posedge clk) begin
        if (!nrst) begin
            hi_q    <= '0;
            lo_q    <= '1;
            delta_q <= '0;
            done_q  <= 1'b0;
        end else begin
            done_q <= last;
            if (last) begin
                delta_q <= (busV > hi_q ? busV : hi_q) - (busV < lo_q ? busV : lo_q); // [R10]
                hi_q    <= busV;
                lo_q    <= busV;
            end else begin
                if (busV > hi_q) hi_q <= busV;
                if (busV < lo_q) lo_q <= busV;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_interval_spacing: assert property ( // [R10]
        done_q |=> !done_q [*2])
        else $error("interval ends too close together");

endmodule

// [logic/vfp_curve_top.sv]
// Purpose: v/f curve builder, settings check and input phase loss supervisor
// Assumes: single clock, settings written over a plain strobe port
// Notes:   curve voltages in 0.1 V, frequencies in 0.1 Hz
//
// What this block does
// R1 - pattern select 0 builds curve from seven custom breakpoints
// R2 - pattern select 1, the reset value, uses fixed preset curve
// R3 - breakpoint settings shape the curve only in custom mode
// R4 - preset voltages scaled by rated voltage over 230 V
// R5 - rated voltage ignored in custom mode
// R6 - rated voltage accepted 150.0 V up to class limit
// R7 - midpoint frequency equal minimum gives straight line, midpoint voltage ignored
// R8 - curve checked at power-up and on enter in program mode
// R9 - curve error unless frequencies and voltages descend in order
// R10 - bus voltage max minus min formed each 1.28 s interval
// R11 - spread at or above level detects loss; fault after 10.24 s
// R12 - loss level resets to 7 percent, accepts 1 to 100
// R13 - detection inhibited by level 100, stop, contactor off, adc, accel, low current
// R14 - custom breakpoints reset to factory values
// R15 - preset breakpoints fixed, writes to them refused
// R16 - curve error appears only from program mode or power-up checks
// R17 - phase loss fault holds output off until fault reset
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module vfp_curve_top #(
    parameter int BW        = 12,
    parameter int INTERVAL  = vfp_pkg::INTERVAL_CYC,
    parameter int FAULT_DLY = vfp_pkg::FAULT_CYC
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                nrst,
    // register port
    input  wire logic [7:0]          regAddr,
    input  wire logic [15:0]         regWrData,
    input  wire logic                regWr,
    input  wire logic                regRd,
    output logic [15:0]              regRdData,
    // keypad
    input  wire logic                programMode,
    input  wire logic                enterKey,
    input  wire vfp_pkg::vfp_class_e voltClass,
    // output stage
    input  wire logic [15:0]         outFreq,
    output logic [15:0]              outVolt,
    // phase loss supervision
    input  wire logic [BW-1:0]       dcBus,
    input  wire logic                stopCmd,
    input  wire logic                contactorOn,
    input  wire logic                adcFault,
    input  wire logic                accelerating,
    input  wire logic [7:0]          outCurrentPct,
    input  wire logic                faultReset,
    // status outputs
    output logic                     curveError,
    output logic                     phaseLossFault,
    output logic                     irq
);
    import vfp_pkg::*;

    typedef enum logic [1:0] {PL_IDLE, PL_WAIT, PL_FAULT} vfp_pl_e;

    localparam logic [31:0] BUS_FULL = 32'((1 << BW) - 1);

    logic              patternQ;
    vfp_curve_s        custQ;
    vfp_curve_s        presetScaled;
    vfp_curve_s        effCurve;
    logic [15:0]       ratedQ;
    logic [15:0]       ratedMax;
    logic [7:0]        levelQ;
    logic              ratedOk;
    logic              levelOk;
    logic              isBp;
    logic              refuse;
    logic              pwrChkQ;
    logic              doCheck;
    logic              checkFail;
    logic [BW-1:0]     delta;
    logic              intervalDone;
    logic              inhibit;
    logic              overLevel;
    logic              detect;
    vfp_pl_e           plState_q;
    logic [31:0]       holdCnt_q;
    logic              faultRise;
    logic [NST-1:0]    status_q;
    logic [NST-1:0]    status_d;
    logic [NST-1:0]    mask_q;
    logic [NST-1:0]    events;
    logic [NST-1:0]    clrBits;

    // preset voltage scaling by rated voltage
    function automatic logic [15:0] scaleV(input logic [15:0] v, input logic [15:0] r);
        scaleV = 16'((32'(v) * 32'(r)) / 32'(BASE_VOLT));
    endfunction

    // write acceptance tests
    always_comb begin
        case (voltClass)
            CLS_230: ratedMax = RATED_230;
            CLS_460: ratedMax = RATED_460;
            CLS_575: ratedMax = RATED_575;
            default: ratedMax = RATED_230;
        endcase
    end
    assign ratedOk = (regWrData >= RATED_MIN) && (regWrData <= ratedMax); // [R6]
    assign levelOk = (regWrData[15:8] == 8'h00) && (regWrData[7:0] >= LEVEL_MIN)
                  && (regWrData[7:0] <= LEVEL_MAX); // [R12]
    assign isBp    = (regAddr >= OFS_MAXF) && (regAddr <= OFS_MINV)
                  && (regAddr[1:0] == 2'b00);
    assign refuse  = regWr && ((isBp && patternQ) // [R15]
                  || (regAddr == OFS_RATED && !ratedOk)
                  || (regAddr == OFS_LEVEL && !levelOk));

    // pattern select
    always_ff @(posedge clk) begin
        if (!nrst) begin
            patternQ <= RST_PATTERN; // [R2]
        end else if (regWr && regAddr == OFS_CTRL) begin
            patternQ <= regWrData[0];
        end
    end

    // custom breakpoints; preset mode locks them
    always_ff @(posedge clk) begin
        if (!nrst) begin
            custQ <= CUSTOM_RST; // [R14]
        end else if (regWr && isBp && !patternQ) begin
            case (regAddr)
                OFS_MAXF:  custQ.maxF  <= regWrData;
                OFS_MAXV:  custQ.maxV  <= regWrData;
                OFS_KNEEF: custQ.kneeF <= regWrData;
                OFS_MIDF:  custQ.midF  <= regWrData;
                OFS_MIDV:  custQ.midV  <= regWrData;
                OFS_MINF:  custQ.minF  <= regWrData;
                OFS_MINV:  custQ.minV  <= regWrData;
                default:   custQ       <= custQ;
            endcase
        end
    end

    // rated voltage and loss level, out-of-range writes keep the old value
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ratedQ <= RST_RATED;
            levelQ <= RST_LEVEL;
        end else if (regWr) begin
            if (regAddr == OFS_RATED && ratedOk) ratedQ <= regWrData;
            if (regAddr == OFS_LEVEL && levelOk) levelQ <= regWrData[7:0];
        end
    end

    // effective curve: frequencies of the preset stay, voltages follow rating
    always_comb begin
        presetScaled      = PRESET;
        presetScaled.maxV = scaleV(PRESET.maxV, ratedQ); // [R4]
        presetScaled.midV = scaleV(PRESET.midV, ratedQ);
        presetScaled.minV = scaleV(PRESET.minV, ratedQ);
        effCurve = patternQ ? presetScaled : custQ; // [R1] [R3] [R5]
    end

    vfp_interp u_interp (
        .clk    (clk),
        .nrst   (nrst),
        .curve  (effCurve),
        .freq   (outFreq),
        .volt_q (outVolt)
    );

    // settings check: once after reset, then on enter in program mode
    assign doCheck   = pwrChkQ || (enterKey && programMode); // [R8]
    assign checkFail = doCheck && !vfp_curve_ok(effCurve); // [R9]

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pwrChkQ    <= 1'b1;
            curveError <= 1'b0;
        end else begin
            pwrChkQ <= 1'b0;
            if (doCheck) begin
                curveError <= checkFail; // [R16]
            end
        end
    end

    vfp_ripple #(
        .BW       (BW),
        .INTERVAL (INTERVAL)
    ) u_ripple (
        .clk     (clk),
        .nrst    (nrst),
        .busV    (dcBus),
        .delta_q (delta),
        .done_q  (intervalDone)
    );

    // level as percent of bus full scale
    assign inhibit   = (levelQ == LEVEL_MAX) || stopCmd || !contactorOn || adcFault
                    || accelerating || (outCurrentPct <= CURRENT_MIN); // [R13]
    assign overLevel = (32'(delta) * 32'(LEVEL_MAX)) >= (32'(levelQ) * BUS_FULL);
    assign detect    = intervalDone && overLevel && !inhibit; // [R11]
    assign faultRise = (plState_q == PL_WAIT) && !inhibit
                    && (holdCnt_q == 32'(FAULT_DLY - 1));

    // loss supervisor: detect, wait, latch fault until reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            plState_q      <= PL_IDLE;
            holdCnt_q      <= 32'h0000_0000;
            phaseLossFault <= 1'b0;
        end else begin
            case (plState_q)
                PL_IDLE: begin
                    holdCnt_q <= 32'h0000_0000;
                    if (detect) plState_q <= PL_WAIT;
                end
                PL_WAIT: begin
                    // an inhibit while waiting cancels the pending trip
                    if (inhibit) begin
                        plState_q <= PL_IDLE; // [R13]
                    end else if (faultRise) begin
                        plState_q      <= PL_FAULT; // [R11]
                        phaseLossFault <= 1'b1;
                    end else begin
                        holdCnt_q <= holdCnt_q + 32'h0000_0001;
                    end
                end
                PL_FAULT: begin
                    if (faultReset) begin
                        plState_q      <= PL_IDLE; // [R17]
                        phaseLossFault <= 1'b0;
                    end
                end
                default: plState_q <= PL_IDLE;
            endcase
        end
    end

    // sticky status, write one to clear, a new event wins over the clear
    always_comb begin
        events            = '0;
        events[ST_CURVE]  = checkFail;
        events[ST_DETECT] = detect;
        events[ST_FAULT]  = faultRise;
        events[ST_REFUSE] = refuse;
        clrBits  = (regWr && regAddr == OFS_STATUS) ? regWrData[NST-1:0] : '0;
        status_d = (status_q & ~clrBits) | events;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            status_q <= '0;
            mask_q   <= '0;
            irq      <= 1'b0;
        end else begin
            status_q <= status_d;
            irq      <= |(status_d & mask_q);
            if (regWr && regAddr == OFS_MASK) mask_q <= regWrData[NST-1:0];
        end
    end

    // read port, data one cycle after the strobe, unmapped reads zero
    always_ff @(posedge clk) begin
        if (!nrst) begin
            regRdData <= 16'h0000;
        end else if (regRd) begin
            case (regAddr)
                OFS_CTRL:   regRdData <= {15'h0000, patternQ};
                OFS_MAXF:   regRdData <= effCurve.maxF;
                OFS_MAXV:   regRdData <= effCurve.maxV;
                OFS_KNEEF:  regRdData <= effCurve.kneeF;
                OFS_MIDF:   regRdData <= effCurve.midF;
                OFS_MIDV:   regRdData <= effCurve.midV;
                OFS_MINF:   regRdData <= effCurve.minF;
                OFS_MINV:   regRdData <= effCurve.minV;
                OFS_RATED:  regRdData <= ratedQ;
                OFS_LEVEL:  regRdData <= {8'h00, levelQ};
                OFS_STATUS: regRdData <= {12'h000, status_q};
                OFS_MASK:   regRdData <= {12'h000, mask_q};
                OFS_STATE:  regRdData <= {1'b0, inhibit, plState_q, 12'(delta)};
                default:    regRdData <= 16'h0000;
            endcase
        end else begin
            regRdData <= 16'h0000;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // wait completes uninhibited, fault must follow
    sequence sWaitEnd;
        plState_q == PL_WAIT && !inhibit && holdCnt_q == 32'(FAULT_DLY - 1);
    endsequence

    sequence sFaultUp;
        phaseLossFault && plState_q == PL_FAULT;
    endsequence

    a_fault_after_wait: assert property ( // [R11]
        sWaitEnd |=> sFaultUp)
        else $error("fault not raised at end of wait");
    a_fault_holds: assert property ( // [R17]
        phaseLossFault && !faultReset |=> phaseLossFault)
        else $error("fault dropped without reset");
    a_inhibit_cancels: assert property ( // [R13]
        (plState_q == PL_WAIT && inhibit) |=> plState_q == PL_IDLE && !phaseLossFault)
        else $error("inhibit did not cancel pending trip");
    a_preset_locked: assert property ( // [R15]
        (regWr && isBp && patternQ) |=> $stable(custQ))
        else $error("preset breakpoint write accepted");
    a_level_range: assert property ( // [R12]
        levelQ >= LEVEL_MIN && levelQ <= LEVEL_MAX)
        else $error("loss level out of range");
    a_rated_floor: assert property ( // [R6]
        (regWr && regAddr == OFS_RATED && regWrData < RATED_MIN) |=> $stable(ratedQ))
        else $error("rated voltage below floor accepted");
    a_check_result: assert property ( // [R9]
        (doCheck && !vfp_curve_ok(effCurve)) |=> curveError && status_q[ST_CURVE])
        else $error("bad curve not flagged");
    a_error_source: assert property ( // [R16]
        $rose(curveError) |-> $past(pwrChkQ) || $past(programMode && enterKey))
        else $error("curve error raised outside check points");
    a_custom_ignores_rating: assert property ( // [R5]
        !patternQ |-> effCurve == custQ)
        else $error("custom curve altered");
    a_preset_scaled: assert property ( // [R4]
        patternQ |-> effCurve.maxV == 16'((32'(PRESET.maxV) * 32'(ratedQ)) / 32'(BASE_VOLT)))
        else $error("preset maximum voltage not scaled");
    a_check_pass: assert property ( // [R9]
        (doCheck && vfp_curve_ok(effCurve)) |=> !curveError)
        else $error("good curve flagged");
    a_rated_ceiling: assert property ( // [R6]
        (regWr && regAddr == OFS_RATED && regWrData > ratedMax) |=> $stable(ratedQ))
        else $error("rated voltage above class limit accepted");
    a_refuse_flag: assert property ( // [R15]
        refuse |=> status_q[ST_REFUSE])
        else $error("refused write not flagged");
    a_pattern_write: assert property ( // [R1]
        (regWr && regAddr == OFS_CTRL) |=> patternQ == $past(regWrData[0]))
        else $error("pattern select write lost");
    // a loss seen while idle starts the delay count from zero
    a_detect_waits: assert property ( // [R11]
        (plState_q == PL_IDLE && detect) |=> plState_q == PL_WAIT && holdCnt_q == '0)
        else $error("detected loss did not start wait");
    a_idle_inhibit: assert property ( // [R13]
        (plState_q == PL_IDLE && inhibit) |=> plState_q == PL_IDLE)
        else $error("inhibited supervisor left idle");
    a_reset_clears: assert property ( // [R17]
        (plState_q == PL_FAULT && faultReset) |=> !phaseLossFault && plState_q == PL_IDLE)
        else $error("fault reset did not clear fault");

endmodule

// [sim/vfp_stage_model.sv]
// Purpose: inverter stage and motor stand-in for the curve block
// Assumes: bus ripple grows only while one input phase is dropped
// Notes:   motor coasts with no current while the loss fault holds
`timescale 1ns/1ps
module vfp_stage_model (
    // clock and reset
    input  wire logic   clk,
    input  wire logic   nrst,
    // control from bench and block
    input  wire logic   dropPhase,
    input  wire logic   lossFault,
    // sensed values
    output logic [11:0] dcBus,
    output logic [7:0]  curPct
);
    logic tgl_q;
    // half-rate toggle gives the ripple its shape
    always_ff @(posedge clk) begin
        if (!nrst) tgl_q <= 1'b0;
        else tgl_q <= ~tgl_q;
    end
    // steady bus unless a phase is missing
    assign dcBus  = (dropPhase && tgl_q) ? 12'h7d0 : 12'hbb8;
    // no current once output is off, which also inhibits detection
    assign curPct = lossFault ? 8'h00 : 8'h32;
endmodule

// [sim/testbench.sv]
// Purpose: self-checking bench for the v/f curve and phase loss block
// Assumes: short interval and fault delay parameters
// Notes:   preset curve rows in a table, awkward cases by hand
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, a, e); end end
module testbench;
    import vfp_pkg::*;
    logic clk, nrst, regWr, regRd, programMode, enterKey, stopCmd, contactorOn;
    logic adcFault, accelerating, faultReset, dropPhase, curveError, phaseLossFault, irq;
    logic [7:0] regAddr, curPct;
    logic [15:0] regWrData, regRdData, outFreq, outVolt;
    logic [11:0] dcBus;
    vfp_class_e voltClass;
    int error_cnt, num_checks, cyc;
    logic [15:0] rowF [6] = '{16'h0000, 16'h000f, 16'h0014, 16'h012c, 16'h0258, 16'h02bc};
    logic [15:0] rowV [6] = '{16'h0073, 16'h0073, 16'h0086, 16'h049c, 16'h08fc, 16'h08fc};

    vfp_curve_top #(.BW(12), .INTERVAL(16), .FAULT_DLY(20)) dut (.clk(clk), .nrst(nrst),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .programMode(programMode), .enterKey(enterKey),
        .voltClass(voltClass), .outFreq(outFreq), .outVolt(outVolt), .dcBus(dcBus),
        .stopCmd(stopCmd), .contactorOn(contactorOn), .adcFault(adcFault),
        .accelerating(accelerating), .outCurrentPct(curPct), .faultReset(faultReset),
        .curveError(curveError), .phaseLossFault(phaseLossFault), .irq(irq));
    vfp_stage_model stage (.clk(clk), .nrst(nrst), .dropPhase(dropPhase),
        .lossFault(phaseLossFault), .dcBus(dcBus), .curPct(curPct));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // hang guard, run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            complete_run();
        end
    end

    task automatic complete_run;
        if (error_cnt == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk) begin regWr <= 1'b1; regAddr <= a; regWrData <= d; end
        @(posedge clk) regWr <= 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk) begin regRd <= 1'b1; regAddr <= a; end
        @(posedge clk) regRd <= 1'b0;
        #1 `CHK(regRdData, e)
    endtask
    task automatic vChk(input logic [15:0] f, input logic [15:0] e);
        @(posedge clk) outFreq <= f;
        repeat (2) @(posedge clk);
        #1 `CHK(outVolt, e)
    endtask
    // enter held one cycle inside program mode, then leave it
    task automatic pressEnter;
        @(posedge clk) begin programMode <= 1'b1; enterKey <= 1'b1; end
        @(posedge clk) begin programMode <= 1'b0; enterKey <= 1'b0; end
        @(posedge clk) #1;
    endtask

    // main sequence
    initial begin
        {nrst, regWr, regRd, programMode, enterKey, stopCmd} = '0;
        {adcFault, accelerating, faultReset, dropPhase} = '0;
        regAddr = '0; regWrData = '0; outFreq = '0; contactorOn = 1'b1; voltClass = CLS_230;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        #1 `CHK(curveError, 1'b0)
        rdChk(OFS_CTRL, 16'h0001);
        rdChk(OFS_LEVEL, 16'h0007);
        wr(OFS_LEVEL, 16'h0065);
        rdChk(OFS_LEVEL, 16'h0007);
        wr(OFS_LEVEL, 16'h0014);
        rdChk(OFS_LEVEL, 16'h0014);
        rdChk(OFS_MIDV, 16'h00ac);
        for (int i = 0; i < 6; i++) vChk(rowF[i], rowV[i]);
        wr(OFS_MAXF, 16'h0100);
        rdChk(OFS_MAXF, 16'h0258);
        rdChk(OFS_STATUS, 16'h0008);
        wr(OFS_STATUS, 16'h000f);
        wr(OFS_RATED, 16'h05db);
        rdChk(OFS_RATED, 16'h08fc);
        voltClass <= CLS_460;
        wr(OFS_RATED, 16'h11f8);
        rdChk(OFS_MAXV, 16'h11f8);
        rdChk(OFS_MINV, 16'h00e6);
        vChk(16'h02bc, 16'h11f8);
        wr(OFS_CTRL, 16'h0000);
        rdChk(OFS_MAXV, 16'h08fc);
        rdChk(OFS_MIDV, 16'h023f);
        vChk(16'h012c, 16'h023f);
        wr(OFS_MIDF, 16'h000f);
        wr(OFS_MIDV, 16'h07d0);
        vChk(16'h012c, 16'h049b);
        // broken order stays silent until a program-mode check
        wr(OFS_MINV, 16'h0960);
        wr(OFS_MASK, 16'h0001);
        @(posedge clk) #1 `CHK(curveError, 1'b0)
        pressEnter();
        `CHK(curveError, 1'b1)
        @(posedge clk) #1 `CHK(irq, 1'b1)
        wr(OFS_STATUS, 16'h0001);
        @(posedge clk) #1 `CHK(irq, 1'b0)
        wr(OFS_MINV, 16'h0073);
        pressEnter();
        `CHK(curveError, 1'b0)
        // ripple under a stop command must not trip
        wr(OFS_STATUS, 16'h000f);
        stopCmd <= 1'b1;
        dropPhase <= 1'b1;
        repeat (120) @(posedge clk);
        #1 `CHK(phaseLossFault, 1'b0)
        stopCmd <= 1'b0;
        repeat (18) @(posedge clk);
        #1 `CHK(phaseLossFault, 1'b0)
        for (int i = 0; i < 60 && phaseLossFault !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        #1 `CHK(phaseLossFault, 1'b1)
        rdChk(OFS_STATUS, 16'h0006);
        dropPhase <= 1'b0;
        repeat (30) @(posedge clk);
        #1 `CHK(phaseLossFault, 1'b1)
        @(posedge clk) faultReset <= 1'b1;
        @(posedge clk) faultReset <= 1'b0;
        @(posedge clk) #1 `CHK(phaseLossFault, 1'b0)
        // converter fault blocks detection even with a phase missing
        adcFault <= 1'b1;
        dropPhase <= 1'b1;
        repeat (60) @(posedge clk);
        #1 `CHK(phaseLossFault, 1'b0)
        complete_run();
    end
endmodule
